// ### include/hpl_params.svh
// constants of the hit-pattern pulse latch: timing, field widths and reset values
`ifndef HPL_PARAMS_SVH
`define HPL_PARAMS_SVH

`define HPL_CHANNELS 18
`define HPL_CLK_PERIOD_NS 25
`define HPL_STEP_NS 50
`define HPL_STEP_CYC (`HPL_STEP_NS / `HPL_CLK_PERIOD_NS)
`define HPL_WIDTH_BASE_NS 150
`define HPL_WIDTH_BASE_CYC ((`HPL_WIDTH_BASE_NS + `HPL_CLK_PERIOD_NS - 1) / `HPL_CLK_PERIOD_NS)
`define HPL_DELAY_BASE_NS 850
`define HPL_DELAY_BASE_CYC ((`HPL_DELAY_BASE_NS + `HPL_CLK_PERIOD_NS - 1) / `HPL_CLK_PERIOD_NS)
`define HPL_HOLD_BASE_NS 250
`define HPL_HOLD_BASE_CYC ((`HPL_HOLD_BASE_NS + `HPL_CLK_PERIOD_NS - 1) / `HPL_CLK_PERIOD_NS)
`define HPL_SYNC_LATENCY_CYC 3
`define HPL_DELAY_DEPTH 128
`define HPL_WIDTH_BITS 4
`define HPL_DELAY_BITS 5
`define HPL_EXT_BITS 3
`define HPL_HOLD_BITS 6
`define HPL_DATA_BITS 16
`define HPL_WIDTH_RESET 4'h0
`define HPL_DELAY_RESET 5'h00
`define HPL_EXT_RESET 3'h0
`define HPL_HOLD_RESET 6'h00
`define HPL_MUX_RESET 16'h0000
`define HPL_MUX_HIT_TEST 16'h0300

`endif

// ### include/hpl_pkg.sv
// types of the hit-pattern pulse latch
package hpl_pkg;

  typedef enum logic [3:0] {
    hpl_cmd_none,
    hpl_cmd_test_mux_select_write,
    hpl_cmd_test_mux_select_read,
    hpl_cmd_pulse_width_write,
    hpl_cmd_pulse_width_read,
    hpl_cmd_pulse_delay_write,
    hpl_cmd_pulse_delay_read,
    hpl_cmd_trailing_extension_write,
    hpl_cmd_trailing_extension_read,
    hpl_cmd_hold_delay_write,
    hpl_cmd_hold_delay_read,
    hpl_cmd_trigger_unsuppressed,
    hpl_cmd_controller_reset
  } hpl_cmd_t;

  typedef enum {
    hpl_hold_idle,
    hpl_hold_wait
  } hpl_hold_state_t;

endpackage

// ### testbench/hpl_assertions.sv
// checker on the ports of the hit-pattern pulse latch
`timescale 1ns/100ps
module hpl_checker #(
  parameter int CHANNELS = 18
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [CHANNELS-1:0] disc_in,
  input wire logic cmd_valid,
  input wire hpl_pkg::hpl_cmd_t cmd_code,
  input wire logic [15:0] cmd_data,
  input wire logic rsp_valid,
  input wire logic [15:0] rsp_data,
  input wire logic [CHANNELS-1:0] hit_pattern,
  input wire logic hit_pattern_valid,
  input wire logic hit_pulse_test_out
);
  logic [15:0] mux_s, rd_exp;
  logic [3:0] wid_s;
  logic [4:0] dly_s;
  logic [2:0] ext_s;
  logic [5:0] hold_s;
  logic busy, mux_off_q, rd, clr, trig;
  int cnt, tgt;
  assign clr = reset || (cmd_valid && cmd_code == hpl_pkg::hpl_cmd_controller_reset);
  // the design is idle again in the cycle its latch flag shows, so a trigger there is taken
  assign trig = cmd_valid && cmd_code == hpl_pkg::hpl_cmd_trigger_unsuppressed && (!busy || hit_pattern_valid);
  // expected answer of a read taken this cycle
  always_comb begin
    rd = cmd_valid;
    case (cmd_code)
      hpl_pkg::hpl_cmd_test_mux_select_read: rd_exp = mux_s;
      hpl_pkg::hpl_cmd_pulse_width_read: rd_exp = {12'h000, wid_s};
      hpl_pkg::hpl_cmd_pulse_delay_read: rd_exp = {11'h000, dly_s};
      hpl_pkg::hpl_cmd_trailing_extension_read: rd_exp = {13'h0000, ext_s};
      hpl_pkg::hpl_cmd_hold_delay_read: rd_exp = {10'h000, hold_s};
      default: begin
        rd = 1'b0;
        rd_exp = 16'h0000;
      end
    endcase
  end
  always_ff @(posedge clk) begin
    mux_off_q <= mux_s != 16'h0300;
    if (clr) begin
      {mux_s, wid_s, dly_s, ext_s, hold_s, busy} <= '0;
      cnt <= 0;
      tgt <= 0;
    end else begin
      if (cmd_valid) begin
        case (cmd_code)
          hpl_pkg::hpl_cmd_test_mux_select_write: mux_s <= cmd_data;
          hpl_pkg::hpl_cmd_pulse_width_write: wid_s <= cmd_data[3:0];
          hpl_pkg::hpl_cmd_pulse_delay_write: dly_s <= cmd_data[4:0];
          hpl_pkg::hpl_cmd_trailing_extension_write: ext_s <= cmd_data[2:0];
          hpl_pkg::hpl_cmd_hold_delay_write: hold_s <= cmd_data[5:0];
          default: ;
        endcase
      end
      if (trig) begin
        busy <= 1'b1;
        cnt <= 0;
        tgt <= 10 + 2 * hold_s;
      end else if (hit_pattern_valid) begin
        busy <= 1'b0;
      end else if (busy) begin
        cnt <= cnt + 1;
      end
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  read_answer_a: assert property (rsp_valid == $past(rd)) else $error("read answer missing or stray");
  read_data_a: assert property (rsp_valid |-> rsp_data == $past(rd_exp)) else $error("read data wrong");
  idle_data_a: assert property (!rsp_valid |-> rsp_data == 16'h0000) else $error("data without answer");
  latch_time_a: assert property (hit_pattern_valid |-> busy && cnt == tgt) else $error("latch off time");
  latch_bound_a: assert property (busy |-> cnt <= tgt) else $error("latch overdue");
  latch_pulse_a: assert property (hit_pattern_valid |=> !hit_pattern_valid) else $error("latch flag long");
  latch_hold_a: assert property (!hit_pattern_valid && !$past(clr) |-> $stable(hit_pattern))
    else $error("hit bits moved");
  test_pin_off_a: assert property (mux_off_q && mux_s != 16'h0300 |-> !hit_pulse_test_out)
    else $error("test pin not muted");
  reset_clear_a: assert property ($past(clr) |-> hit_pattern == '0 && !hit_pattern_valid)
    else $error("reset left hit bits");
endmodule
bind hpl_top hpl_checker #(.CHANNELS(CHANNELS)) chk (.clk(clk), .reset(reset), .disc_in(disc_in),
  .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_data(cmd_data), .rsp_valid(rsp_valid),
  .rsp_data(rsp_data), .hit_pattern(hit_pattern), .hit_pattern_valid(hit_pattern_valid),
  .hit_pulse_test_out(hit_pulse_test_out));

// ### testbench/hpl_host_model.sv
// event electronics model: command issuer and discriminator pulser
`timescale 1ns/100ps
module hpl_host_model (
  input wire logic clk,
  input wire logic rsp_valid,
  input wire logic [15:0] rsp_data,
  output logic cmd_valid,
  output hpl_pkg::hpl_cmd_t cmd_code,
  output logic [15:0] cmd_data,
  output logic [17:0] disc_in
);
  initial begin
    cmd_valid = 1'b0;
    cmd_code = hpl_pkg::hpl_cmd_none;
    cmd_data = 16'h0000;
    disc_in = 18'h00000;
  end
  // one-cycle command; data is inverted once released so stale values never look valid
  task send(input hpl_pkg::hpl_cmd_t c, input logic [15:0] v);
    @(posedge clk);
    #1 cmd_valid = 1'b1;
    cmd_code = c;
    cmd_data = v;
    @(posedge clk);
    #1 cmd_valid = 1'b0;
    cmd_code = hpl_pkg::hpl_cmd_none;
    cmd_data = ~v;
  endtask
  task read(input hpl_pkg::hpl_cmd_t c, output logic [15:0] v);
    // the answer stands in the one cycle after the take edge, which is where send returns
    send(c, 16'h0000);
    v = (rsp_valid === 1'b1) ? rsp_data : 16'hxxxx;
  endtask
  task set_disc(input logic [17:0] m);
    disc_in = m;
  endtask
endmodule

// ### testbench/hpl_top_test.sv
// self-checking bench of the hit-pattern pulse latch
`timescale 1ns/100ps
module hpl_top_test;
  logic clk, reset, cmd_valid, rsp_valid, hit_pattern_valid, hit_pulse_test_out;
  logic [17:0] disc_in, hit_pattern;
  hpl_pkg::hpl_cmd_t cmd_code;
  logic [15:0] cmd_data, rsp_data;
  int n_errors, check_count, cyc, r, w, n, r0, k;
  hpl_top dut (
    .clk(clk),
    .reset(reset),
    .disc_in(disc_in),
    .cmd_valid(cmd_valid),
    .cmd_code(cmd_code),
    .cmd_data(cmd_data),
    .rsp_valid(rsp_valid),
    .rsp_data(rsp_data),
    .hit_pattern(hit_pattern),
    .hit_pattern_valid(hit_pattern_valid),
    .hit_pulse_test_out(hit_pulse_test_out)
  );
  hpl_host_model host (
    .clk(clk),
    .rsp_valid(rsp_valid),
    .rsp_data(rsp_data),
    .cmd_valid(cmd_valid),
    .cmd_code(cmd_code),
    .cmd_data(cmd_data),
    .disc_in(disc_in)
  );
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      n_errors++;
      print_verdict();
    end
  end
  task check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task print_verdict;
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task rdck(input hpl_pkg::hpl_cmd_t c, input logic [15:0] e);
    logic [15:0] v;
    host.read(c, v);
    check(v, e);
  endtask
  // pulse pair on the masked inputs; measures the test pin: first rise, first width, pulse count
  task shot(input logic [17:0] m, input int l1, input int sp, input int l2);
    logic p;
    r = 0;
    w = 0;
    n = 0;
    p = 1'b0;
    for (int t = 0; t < 220; t++) begin
      @(posedge clk);
      #1 host.set_disc((t < l1 || (t >= sp && t < sp + l2)) ? m : 18'h00000);
      if (hit_pulse_test_out === 1'b1 && !p) begin
        n++;
        if (n == 1) r = t;
      end
      if (hit_pulse_test_out === 1'b1 && n == 1) w++;
      p = hit_pulse_test_out;
    end
  endtask
  task latch;
    host.send(hpl_pkg::hpl_cmd_trigger_unsuppressed, 16'h0000);
    for (k = 0; k < 100 && hit_pattern_valid !== 1'b1; k++) begin
      @(posedge clk);
      #1;
    end
  endtask
  initial begin
    reset = 1'b1;
    repeat (3) @(posedge clk);
    #1 reset = 1'b0;
    rdck(hpl_pkg::hpl_cmd_pulse_width_read, 16'h0000);
    rdck(hpl_pkg::hpl_cmd_pulse_delay_read, 16'h0000);
    rdck(hpl_pkg::hpl_cmd_trailing_extension_read, 16'h0000);
    host.send(hpl_pkg::hpl_cmd_test_mux_select_write, 16'h0300);
    rdck(hpl_pkg::hpl_cmd_test_mux_select_read, 16'h0300);
    shot(18'h3fffe, 3, 0, 0);
    check(n, 0);
    $display("test reset and mux done");
    for (int i = 0; i < 16; i++) begin
      host.send(hpl_pkg::hpl_cmd_pulse_width_write, 16'(i));
      rdck(hpl_pkg::hpl_cmd_pulse_width_read, 16'(i));
      shot(18'h00001, 3, 0, 0);
      check(w, 6 + 2 * i);
    end
    host.send(hpl_pkg::hpl_cmd_pulse_width_write, 16'h0000);
    shot(18'h00001, 3, 0, 0);
    r0 = r;
    check(r0 >= 34 && r0 <= 37, 1);
    for (int i = 1; i < 32; i++) begin
      host.send(hpl_pkg::hpl_cmd_pulse_delay_write, 16'(i));
      rdck(hpl_pkg::hpl_cmd_pulse_delay_read, 16'(i));
      shot(18'h00001, 3, 0, 0);
      check(r - r0, 2 * i);
    end
    host.send(hpl_pkg::hpl_cmd_pulse_delay_write, 16'h0000);
    for (int i = 0; i < 8; i++) begin
      host.send(hpl_pkg::hpl_cmd_trailing_extension_write, 16'(i));
      rdck(hpl_pkg::hpl_cmd_trailing_extension_read, 16'(i));
      shot(18'h00001, 3, 0, 0);
      check(w, 6 + 2 * i);
    end
    host.send(hpl_pkg::hpl_cmd_trailing_extension_write, 16'h0000);
    $display("test width delay extension done");
    shot(18'h00001, 40, 0, 0);
    check(w, 40);
    shot(18'h00001, 3, 4, 3);
    check(n, 1);
    check(w, 10);
    $display("test long and merged pulses done");
    host.send(hpl_pkg::hpl_cmd_hold_delay_write, 16'd25);
    rdck(hpl_pkg::hpl_cmd_hold_delay_read, 16'd25);
    host.send(hpl_pkg::hpl_cmd_pulse_delay_write, 16'd14);
    @(posedge clk);
    #1 host.set_disc(18'h2aaaa);
    repeat (3) @(posedge clk);
    #1 host.set_disc(18'h00000);
    latch();
    check(k, 60);
    check(hit_pattern, 18'h2aaaa);
    latch();
    check(hit_pattern, 18'h00000);
    $display("test hit latch done");
    host.send(hpl_pkg::hpl_cmd_pulse_width_write, 16'h0005);
    host.send(hpl_pkg::hpl_cmd_controller_reset, 16'h0000);
    rdck(hpl_pkg::hpl_cmd_pulse_width_read, 16'h0000);
    rdck(hpl_pkg::hpl_cmd_pulse_delay_read, 16'h0000);
    rdck(hpl_pkg::hpl_cmd_test_mux_select_read, 16'h0000);
    rdck(hpl_pkg::hpl_cmd_hold_delay_read, 16'h0000);
    // mux back at its reset value: a channel 00 pulse must not reach the test pin
    shot(18'h00001, 3, 0, 0);
    check(n, 0);
    $display("test reset command done");
    print_verdict();
  end
endmodule

// ### verilog/hpl_channel.sv
// one channel: input synchroniser, programmable delay line and pulse shaper
`timescale 1ns/100ps
`include "hpl_params.svh"

module hpl_channel #(
  parameter int DEPTH = `HPL_DELAY_DEPTH
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic disc_in,
  input wire logic [6:0] delay_tap,
  input wire logic [5:0] width_cyc,
  input wire logic [3:0] ext_cyc,
  output logic shaped_out
);

  logic sync1;
  logic sync2;
  logic [DEPTH-1:0] line;
  logic del_q;
  logic [5:0] width_cnt;
  logic [3:0] ext_cnt;
  logic next_sync1;
  logic next_sync2;
  logic [DEPTH-1:0] next_line;
  logic next_del_q;
  logic [5:0] next_width_cnt;
  logic [3:0] next_ext_cnt;
  logic next_shaped_out;
  logic del;
  logic active;

  always_comb begin
    next_sync1 = disc_in;
    // second stage alone reads the first
    next_sync2 = sync1;
    next_line = {line[DEPTH-2:0], sync2};
    del = line[delay_tap];
    next_del_q = del;
    // leading edge retriggers the width timer
    if (del && !del_q) begin
      next_width_cnt = width_cyc - 6'd1;
    end else if (width_cnt != 6'd0) begin
      next_width_cnt = width_cnt - 6'd1;
    end else begin
      next_width_cnt = 6'd0;
    end
    // long input holds the pulse on past the width close pulses merge
    active = del || (width_cnt != 6'd0);
    // extension starts where width and input both ended
    if (active) begin
      next_ext_cnt = ext_cyc;
    end else if (ext_cnt != 4'd0) begin
      next_ext_cnt = ext_cnt - 4'd1;
    end else begin
      next_ext_cnt = 4'd0;
    end
    next_shaped_out = active || (ext_cnt != 4'd0);
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      sync1 <= 1'b0;
      sync2 <= 1'b0;
      line <= '0;
      del_q <= 1'b0;
      width_cnt <= 6'd0;
      ext_cnt <= 4'd0;
      shaped_out <= 1'b0;
    end else begin
      sync1 <= next_sync1;
      sync2 <= next_sync2;
      line <= next_line;
      del_q <= next_del_q;
      width_cnt <= next_width_cnt;
      ext_cnt <= next_ext_cnt;
      shaped_out <= next_shaped_out;
    end
  end

endmodule

// ### verilog/hpl_top.sv
// hit-pattern pulse latch: settings commands, 18 shaping channels, trigger hold and latch
`timescale 1ns/100ps
`include "hpl_params.svh"

module hpl_top #(
  parameter int CHANNELS = `HPL_CHANNELS,
  parameter int DEPTH = `HPL_DELAY_DEPTH
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [CHANNELS-1:0] disc_in,
  input wire logic cmd_valid,
  input wire hpl_pkg::hpl_cmd_t cmd_code,
  input wire logic [`HPL_DATA_BITS-1:0] cmd_data,
  output logic rsp_valid,
  output logic [`HPL_DATA_BITS-1:0] rsp_data,
  output logic [CHANNELS-1:0] hit_pattern,
  output logic hit_pattern_valid,
  output logic hit_pulse_test_out
);

  logic [`HPL_DATA_BITS-1:0] test_mux_select;
  logic [`HPL_WIDTH_BITS-1:0] pulse_width_setting;
  logic [`HPL_DELAY_BITS-1:0] pulse_delay_setting;
  logic [`HPL_EXT_BITS-1:0] trailing_extension_setting;
  logic [`HPL_HOLD_BITS-1:0] hold_delay_setting;
  logic [`HPL_DATA_BITS-1:0] next_test_mux_select;
  logic [`HPL_WIDTH_BITS-1:0] next_pulse_width_setting;
  logic [`HPL_DELAY_BITS-1:0] next_pulse_delay_setting;
  logic [`HPL_EXT_BITS-1:0] next_trailing_extension_setting;
  logic [`HPL_HOLD_BITS-1:0] next_hold_delay_setting;
  logic next_rsp_valid;
  logic [`HPL_DATA_BITS-1:0] next_rsp_data;

  hpl_pkg::hpl_hold_state_t hold_state;
  hpl_pkg::hpl_hold_state_t next_hold_state;
  logic [7:0] hold_cnt;
  logic [7:0] next_hold_cnt;
  logic [CHANNELS-1:0] next_hit_pattern;
  logic next_hit_pattern_valid;
  logic next_hit_pulse_test_out;

  logic settings_reset;
  logic [6:0] delay_tap;
  logic [5:0] width_cyc;
  logic [3:0] ext_cyc;
  logic [CHANNELS-1:0] shaped;

  // code to cycle count: base plus one 50 ns step per code
  function automatic logic [7:0] steps_to_cyc(input logic [7:0] base, input logic [7:0] code);
    steps_to_cyc = 8'(base + 8'(code * 8'(`HPL_STEP_CYC)));
  endfunction

  function automatic logic cmd_is(input hpl_pkg::hpl_cmd_t code, input hpl_pkg::hpl_cmd_t want);
    cmd_is = cmd_valid && (code == want);
  endfunction

  // reset command returns all settings
  assign settings_reset = cmd_is(cmd_code, hpl_pkg::hpl_cmd_controller_reset);

  // timers in 50 ns steps, synchroniser latency taken off the delay tap
  assign width_cyc = 6'(steps_to_cyc(8'(`HPL_WIDTH_BASE_CYC), 8'(pulse_width_setting)));
  assign delay_tap = 7'(steps_to_cyc(8'(`HPL_DELAY_BASE_CYC - `HPL_SYNC_LATENCY_CYC),
    8'(pulse_delay_setting)));
  assign ext_cyc = 4'(steps_to_cyc(8'h00, 8'(trailing_extension_setting)));

  genvar ch;
  generate
    for (ch = 0; ch < CHANNELS; ch++) begin : g_chan
      // each channel catches inputs over 25 ns after two-stage sync
      hpl_channel #(
        .DEPTH(DEPTH)
      ) u_chan (
        .clk(clk),
        .reset(reset || settings_reset),
        .disc_in(disc_in[ch]),
        .delay_tap(delay_tap),
        .width_cyc(width_cyc),
        .ext_cyc(ext_cyc),
        .shaped_out(shaped[ch])
      );
    end
  endgenerate

  // settings and read-back
  always_comb begin
    next_test_mux_select = test_mux_select;
    next_pulse_width_setting = pulse_width_setting;
    next_pulse_delay_setting = pulse_delay_setting;
    next_trailing_extension_setting = trailing_extension_setting;
    next_hold_delay_setting = hold_delay_setting;
    next_rsp_valid = 1'b0;
    next_rsp_data = '0;
    if (cmd_valid) begin
      case (cmd_code)
        hpl_pkg::hpl_cmd_test_mux_select_write: begin
          next_test_mux_select = cmd_data;
        end
        hpl_pkg::hpl_cmd_pulse_width_write: begin
          next_pulse_width_setting = cmd_data[`HPL_WIDTH_BITS-1:0];
        end
        hpl_pkg::hpl_cmd_pulse_delay_write: begin
          next_pulse_delay_setting = cmd_data[`HPL_DELAY_BITS-1:0];
        end
        hpl_pkg::hpl_cmd_trailing_extension_write: begin
          next_trailing_extension_setting = cmd_data[`HPL_EXT_BITS-1:0];
        end
        hpl_pkg::hpl_cmd_hold_delay_write: begin
          next_hold_delay_setting = cmd_data[`HPL_HOLD_BITS-1:0];
        end
        hpl_pkg::hpl_cmd_test_mux_select_read: begin
          next_rsp_valid = 1'b1;
          next_rsp_data = test_mux_select;
        end
        hpl_pkg::hpl_cmd_pulse_width_read: begin
          next_rsp_valid = 1'b1;
          next_rsp_data = `HPL_DATA_BITS'(pulse_width_setting);
        end
        hpl_pkg::hpl_cmd_pulse_delay_read: begin
          next_rsp_valid = 1'b1;
          next_rsp_data = `HPL_DATA_BITS'(pulse_delay_setting);
        end
        hpl_pkg::hpl_cmd_trailing_extension_read: begin
          next_rsp_valid = 1'b1;
          next_rsp_data = `HPL_DATA_BITS'(trailing_extension_setting);
        end
        hpl_pkg::hpl_cmd_hold_delay_read: begin
          next_rsp_valid = 1'b1;
          next_rsp_data = `HPL_DATA_BITS'(hold_delay_setting);
        end
        default: begin
          next_rsp_valid = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (reset || settings_reset) begin
      // power-up codes are zero
      test_mux_select <= `HPL_MUX_RESET;
      pulse_width_setting <= `HPL_WIDTH_RESET;
      pulse_delay_setting <= `HPL_DELAY_RESET;
      trailing_extension_setting <= `HPL_EXT_RESET;
      hold_delay_setting <= `HPL_HOLD_RESET;
      rsp_valid <= 1'b0;
      rsp_data <= '0;
    end else begin
      test_mux_select <= next_test_mux_select;
      pulse_width_setting <= next_pulse_width_setting;
      pulse_delay_setting <= next_pulse_delay_setting;
      trailing_extension_setting <= next_trailing_extension_setting;
      hold_delay_setting <= next_hold_delay_setting;
      rsp_valid <= next_rsp_valid;
      rsp_data <= next_rsp_data;
    end
  end

  // trigger, hold wait and latch
  always_comb begin
    next_hold_state = hold_state;
    next_hold_cnt = hold_cnt;
    next_hit_pattern = hit_pattern;
    next_hit_pattern_valid = 1'b0;
    case (hold_state)
      hpl_pkg::hpl_hold_idle: begin
        if (cmd_is(cmd_code, hpl_pkg::hpl_cmd_trigger_unsuppressed)) begin
          // capture instant set by the hold code
          next_hold_cnt = steps_to_cyc(8'(`HPL_HOLD_BASE_CYC), 8'(hold_delay_setting)) - 8'd1;
          next_hold_state = hpl_pkg::hpl_hold_wait;
        end
      end
      hpl_pkg::hpl_hold_wait: begin
        if (hold_cnt != 8'd0) begin
          next_hold_cnt = hold_cnt - 8'd1;
        end else begin
          // levels taken on the capture edge itself all channels
          next_hit_pattern = shaped;
          next_hit_pattern_valid = 1'b1;
          next_hold_state = hpl_pkg::hpl_hold_idle;
        end
      end
      default: begin
        next_hold_state = hpl_pkg::hpl_hold_idle;
      end
    endcase
    // channel 00 alone, and only on selection 768
    next_hit_pulse_test_out = (test_mux_select == `HPL_MUX_HIT_TEST) && shaped[0];
  end

  always_ff @(posedge clk) begin
    if (reset || settings_reset) begin
      hold_state <= hpl_pkg::hpl_hold_idle;
      hold_cnt <= 8'd0;
      hit_pattern <= '0;
      hit_pattern_valid <= 1'b0;
      hit_pulse_test_out <= 1'b0;
    end else begin
      hold_state <= next_hold_state;
      hold_cnt <= next_hold_cnt;
      hit_pattern <= next_hit_pattern;
      hit_pattern_valid <= next_hit_pattern_valid;
      hit_pulse_test_out <= next_hit_pulse_test_out;
    end
  end

endmodule
